// ==== hdl/eufd_params.svh ====
// Field positions, register map and reset values of the instruction field decoder
`ifndef EUFD_PARAMS_SVH
`define EUFD_PARAMS_SVH
`define EUFD_CMOD_HI      27
`define EUFD_CMOD_LO      24
`define EUFD_ES_HI        23
`define EUFD_ES_LO        21
`define EUFD_PINV_BIT     20
`define EUFD_PSEL_HI      19
`define EUFD_PSEL_LO      16
`define EUFD_OPC_HI       6
`define EUFD_OPC_LO       0
`define EUFD_ES_MAX       3'h5
`define EUFD_PSEL_NONE    4'h0
`define EUFD_AW           12
`define EUFD_CTRL_OFF     12'h000
`define EUFD_STAT_OFF     12'h004
`define EUFD_EN_BIT       0
`define EUFD_SOPC_LO      8
`define EUFD_SOPC_HI      14
`define EUFD_CTRL_RST     32'h0000_3101
`define EUFD_ILL_LO       16
`endif

// ==== hdl/eufd_pkg.sv ====
// Types shared by the instruction field decoder
package eufd_pkg;
	typedef logic [3:0] eufd_nib_type;
	typedef enum logic [2:0]
	{
		EUFD_CH1  = 3'h0,
		EUFD_CH2  = 3'h1,
		EUFD_CH4  = 3'h2,
		EUFD_CH8  = 3'h3,
		EUFD_CH16 = 3'h4,
		EUFD_CH32 = 3'h5
	} eufd_es_type;
endpackage

// ==== hdl/eufd_decode.sv ====
// Instruction field decoder: shared flag/message field, channel count, predicate mask
`timescale 1ns/1ps
`include "eufd_params.svh"
// How it works
// - Non-send opcodes: shared field is the flag update condition.
// - Send opcode: shared field is the message destination register index.
// - The four-bit index reaches all sixteen message registers.
// - A send never updates any flag register.
// - Codes 0-5 give 1,2,4,8,16,32 channels; 6 and 7 are reserved.
// - Polarity flip complements the selected predicate bits for the mask.
// - Flip applies after predicate selection, never to raw flags.
// - Select 0000 ignores the flip and applies no predicate masking.
// - Shared field sits at bits 27 to 24.
// - Select 0000 means normal execution in either access mode.
module eufd_decode #(
	parameter int CH_W = 32
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic [`EUFD_AW-1:0]  paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 instr_valid,
	input  wire logic [31:0]          instr_word,
	input  wire logic [CH_W-1:0]      pred_sel_mask,
	output logic                      dec_valid,
	output logic                      is_send,
	output logic                      flag_upd_en,
	output eufd_pkg::eufd_nib_type    flag_update_condition,
	output logic                      msg_dest_valid,
	output eufd_pkg::eufd_nib_type    message_dest_reg_index,
	output logic [5:0]                channel_count,
	output logic                      illegal_exec_size,
	output logic [CH_W-1:0]           exec_mask
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Channel enable mask for a channel count code, zero when reserved
	function automatic logic [CH_W-1:0] chan_mask(input logic [2:0] code);
		logic [63:0] m;
		m = 64'h0;
		if (code <= `EUFD_ES_MAX)
			m = (64'h1 << (7'h1 << code)) - 64'h1;
		return m[CH_W-1:0];
	endfunction

	logic [31:0]                  ctrl_ff;
	logic [15:0]                  ok_cnt_ff;
	logic [15:0]                  ill_cnt_ff;
	logic [31:0]                  prdata_ff;
	logic                         pready_ff;
	logic                         pslverr_ff;
	logic                         dec_valid_ff;
	logic                         is_send_ff;
	logic                         flag_upd_en_ff;
	eufd_pkg::eufd_nib_type       cond_ff;
	logic                         msg_valid_ff;
	eufd_pkg::eufd_nib_type       msg_idx_ff;
	logic [5:0]                   chan_cnt_ff;
	logic                         illegal_ff;
	logic [CH_W-1:0]              exec_mask_ff;
	eufd_pkg::eufd_nib_type       f_shared;
	eufd_pkg::eufd_es_type        f_es;
	logic                         f_flip;
	eufd_pkg::eufd_nib_type       f_psel;
	logic                         f_send;
	logic                         f_ill;
	logic                         take;
	logic [CH_W-1:0]              pred_mask;
	logic                         acc_done;
	logic                         hit_ctrl;
	logic                         hit_stat;
	logic [31:0]                  rd_val;

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	// Slice the fields and classify the opcode
	assign f_shared  = instr_word[`EUFD_CMOD_HI:`EUFD_CMOD_LO];
	assign f_es      = eufd_pkg::eufd_es_type'(instr_word[`EUFD_ES_HI:`EUFD_ES_LO]);
	assign f_flip    = instr_word[`EUFD_PINV_BIT];
	assign f_psel    = instr_word[`EUFD_PSEL_HI:`EUFD_PSEL_LO];
	assign f_send    = instr_word[`EUFD_OPC_HI:`EUFD_OPC_LO] == ctrl_ff[`EUFD_SOPC_HI:`EUFD_SOPC_LO];
	assign f_ill     = f_es > `EUFD_ES_MAX;
	assign take      = ce && instr_valid && ctrl_ff[`EUFD_EN_BIT];

	// Flip the already selected bits; no selection means no masking
	assign pred_mask = (f_psel == `EUFD_PSEL_NONE) ? {CH_W{1'b1}} :
		(pred_sel_mask ^ {CH_W{f_flip}});

	// ----------------------------------------
	// Decode stage
	// ----------------------------------------
	// Valid and opcode class
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dec_valid_ff <= 1'b0;
			is_send_ff   <= 1'b0;
			illegal_ff   <= 1'b0;
		end
		else if (ce)
		begin
			dec_valid_ff <= take;
			is_send_ff   <= take && f_send;
			illegal_ff   <= take && f_ill;
		end
	end

	// Shared field: flag condition or message destination
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_upd_en_ff <= 1'b0;
			cond_ff        <= 4'h0;
			msg_valid_ff   <= 1'b0;
			msg_idx_ff     <= 4'h0;
		end
		else if (ce)
		begin
			flag_upd_en_ff <= take && !f_send && !f_ill;
			cond_ff        <= f_send ? 4'h0 : f_shared;
			msg_valid_ff   <= take && f_send && !f_ill;
			msg_idx_ff     <= f_send ? f_shared : 4'h0;
		end
	end

	// Channel count and execution mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chan_cnt_ff  <= 6'h0;
			exec_mask_ff <= {CH_W{1'b0}};
		end
		else if (ce)
		begin
			chan_cnt_ff  <= (take && !f_ill) ? 6'(7'h1 << f_es) : 6'h0;
			exec_mask_ff <= take ? (chan_mask(f_es) & pred_mask) : {CH_W{1'b0}};
		end
	end

	// Decode and illegal counters for status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ok_cnt_ff  <= 16'h0;
			ill_cnt_ff <= 16'h0;
		end
		else if (ce && take)
		begin
			if (f_ill)
				ill_cnt_ff <= ill_cnt_ff + 16'h1;
			else
				ok_cnt_ff <= ok_cnt_ff + 16'h1;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state; the transfer ends on the edge where pready is high
	assign acc_done = psel && penable && pready_ff;
	assign hit_ctrl = paddr == `EUFD_CTRL_OFF;
	assign hit_stat = paddr == `EUFD_STAT_OFF;
	assign rd_val   = hit_ctrl ? ctrl_ff : hit_stat ? {ill_cnt_ff, ok_cnt_ff} : 32'h0;

	// Response phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end
		else if (ce)
		begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !(hit_ctrl || (hit_stat && !pwrite));
			if (psel && penable && !pready_ff && !pwrite)
				prdata_ff <= rd_val;
		end
	end

	// Control register: enable in byte 0, send opcode in byte 1
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= `EUFD_CTRL_RST;
		else if (ce && acc_done && pwrite && hit_ctrl)
		begin
			if (pstrb[0])
				ctrl_ff[`EUFD_EN_BIT] <= pwdata[`EUFD_EN_BIT];
			if (pstrb[1])
				ctrl_ff[`EUFD_SOPC_HI:`EUFD_SOPC_LO] <= pwdata[`EUFD_SOPC_HI:`EUFD_SOPC_LO];
		end
	end

	assign prdata                 = prdata_ff;
	assign pready                 = pready_ff;
	assign pslverr                = pslverr_ff;
	assign dec_valid              = dec_valid_ff;
	assign is_send                = is_send_ff;
	assign flag_upd_en            = flag_upd_en_ff;
	assign flag_update_condition  = cond_ff;
	assign msg_dest_valid         = msg_valid_ff;
	assign message_dest_reg_index = msg_idx_ff;
	assign channel_count          = chan_cnt_ff;
	assign illegal_exec_size      = illegal_ff;
	assign exec_mask              = exec_mask_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_access;
		(psel && penable && ce) [*2];
	endsequence

	chk_cmod_flag_update: assert property (take && !f_send && !f_ill |=>
		flag_upd_en && flag_update_condition == $past(f_shared))
		else $error("condition not passed to flag update");
	chk_send_dest_index: assert property (take && f_send && !f_ill |=>
		msg_dest_valid && message_dest_reg_index == $past(instr_word[`EUFD_CMOD_HI:`EUFD_CMOD_LO]))
		else $error("message index wrong");
	chk_dest_full_range: assert property (take && f_send && f_shared == 4'hf |=>
		message_dest_reg_index == 4'hf)
		else $error("top message register unreachable");
	chk_send_no_flags: assert property (is_send |-> !flag_upd_en)
		else $error("send updated flags");
	chk_size_decode: assert property (take && f_es == eufd_pkg::EUFD_CH16 |=>
		channel_count == 6'h10 && ($past(f_psel) != `EUFD_PSEL_NONE || exec_mask == 32'h0000_ffff))
		else $error("channel count wrong");
	chk_inverse_after_sel: assert property (take && f_psel != 4'h0 && f_flip |=>
		exec_mask == (chan_mask($past(f_es)) & ~$past(pred_sel_mask)))
		else $error("inverse not after selection");
	chk_no_pred_ignores: assert property (take && f_psel == 4'h0 |=>
		exec_mask == chan_mask($past(f_es)))
		else $error("flip not ignored without predication");
	chk_reserved_flag: assert property (take && f_ill |=>
		illegal_exec_size && exec_mask == '0 && !flag_upd_en && channel_count == 6'h0)
		else $error("reserved size executed");
	chk_apb_one_wait: assert property (s_setup ##1 s_access |-> pready)
		else $error("bus answer late");
endmodule // eufd_decode

// ==== verification/eufd_fetch_model.sv ====
// Instruction fetch model feeding the field decoder
`timescale 1ns/1ps
module eufd_fetch_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        req,
	input  wire logic [31:0] word_in,
	input  wire logic [31:0] mask_in,
	output logic             instr_valid,
	output logic [31:0]      instr_word,
	output logic [31:0]      pred_sel_mask
);
	// One word per request; idle lines invert so stale data never looks valid
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_valid   <= 1'b0;
			instr_word    <= 32'h0;
			pred_sel_mask <= 32'h0;
		end
		else
		begin
			instr_valid   <= req;
			instr_word    <= req ? word_in : ~instr_word;
			pred_sel_mask <= req ? mask_in : ~pred_sel_mask;
		end
	end
endmodule // eufd_fetch_model

// ==== verification/tb.sv ====
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module tb;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, req = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, word_in = 32'h0, mask_in = 32'h0, seed = 32'h2e;
	logic [31:0] prdata, iw, pm, rd, em;
	logic [3:0]  pstrb = 4'h0, fuc, mdi;
	logic        pready, pslverr, iv, dv, snd, fue, mdv, ill, er;
	logic [5:0]  cnt;
	logic [6:0]  sop = 7'h31;
	int          num_errors = 0, compares = 0, nleg = 0, nill = 0;
	always #20 pclk = ~pclk;
	eufd_fetch_model fm_u (.pclk(pclk), .presetn(presetn), .req(req), .word_in(word_in), .mask_in(mask_in),
		.instr_valid(iv), .instr_word(iw), .pred_sel_mask(pm));
	eufd_decode dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(iv), .instr_word(iw), .pred_sel_mask(pm), .dec_valid(dv), .is_send(snd),
		.flag_upd_en(fue), .flag_update_condition(fuc), .msg_dest_valid(mdv), .message_dest_reg_index(mdi),
		.channel_count(cnt), .illegal_exec_size(ill), .exec_mask(em));
	// ----------------
	// Helpers
	// ----------------
	task results();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected decode of one word
	function logic [63:0] exp_of(input logic [31:0] w, input logic [31:0] m);
		logic        s, bad;
		logic [31:0] cm, pk;
		s   = w[6:0] == sop;
		bad = w[23:21] > 3'h5;
		cm  = bad ? 32'h0 : 32'hffffffff >> (6'd32 - (6'd1 << w[23:21]));
		pk  = w[19:16] == 4'h0 ? 32'hffffffff : (w[20] ? ~m : m);
		return {s, !s && !bad, s ? 4'h0 : w[27:24], s && !bad, s ? w[27:24] : 4'h0,
			bad ? 6'h0 : 6'h1 << w[23:21], bad, cm & pk};
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			results();
		end
	endtask
	task ins(input logic [31:0] w, input logic [31:0] m, input logic en);
		@(posedge pclk);
		req     <= 1'b1;
		word_in <= w;
		mask_in <= m;
		@(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
		#1;
		chk({63'h0, dv}, {63'h0, en});
		if (en)
		begin
			chk({snd, fue, fuc, mdv, mdi, cnt, ill, em}, exp_of(w, m));
			if (w[23:21] > 3'h5)
				nill++;
			else
				nleg++;
		end
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		logic [31:0] w;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk({er, rd}, {1'b0, 32'h0000_3101});
		apb(1'b0, 12'h008, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b1, 12'h004, 32'hffff);
		chk({63'h0, er}, 64'h1);
		// Every size code, send and non-send, select none with flip
		for (int i = 0; i < 120; i++)
		begin
			w = rnd();
			if (i < 16)
				w[23:21] = i[2:0];
			if (i[1:0] == 2'h0)
				w[6:0] = sop;
			if (i[2])
				w[19:16] = 4'h0;
			ins(w, rnd(), 1'b1);
		end
		// Clock enable low freezes the decoder: word neither decoded nor counted
		@(posedge pclk);
		ce <= 1'b0;
		ins(rnd(), rnd(), 1'b0);
		@(posedge pclk);
		ce <= 1'b1;
		// Disabled decoder ignores words, then a new send opcode
		apb(1'b1, 12'h000, 32'h0000_1200);
		ins(rnd(), rnd(), 1'b0);
		apb(1'b1, 12'h000, 32'h0000_1201);
		sop = 7'h12;
		ins({4'h0, 4'hf, 3'h5, 1'b1, 4'h1, 9'h0, 7'h12}, 32'h0f0f_0f0f, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk({er, rd}, {1'b0, nill[15:0], nleg[15:0]});
		results();
	end
endmodule // tb
